// ==== shared/cfwt_pkg.sv ====
package cfwt_pkg;
   // telegram codes and lengths
   localparam logic [7:0] CMD_CFG_WR = 8'h66;
   localparam logic [7:0] CMD_FIX_WR = 8'h1f;
   localparam logic [7:0] CMD_FIX_WR_ENH = 8'h24;
   localparam logic [7:0] LEN_HI = 8'h00;
   localparam logic [7:0] LEN_CFG = 8'h0a;
   localparam logic [7:0] LEN_FIX = 8'h0b;
   localparam logic [7:0] LEN_RSP = 8'h06;
   // status codes
   localparam logic [7:0] STAT_OK = 8'h00;
   localparam logic [7:0] STAT_WR_FAIL = 8'h04;
   localparam logic [7:0] STAT_NO_CARRIER = 8'h05;
   // tag types, two ascii characters
   localparam logic [15:0] TAG_EMU_02 = 16'h3032;
   localparam logic [15:0] TAG_EMU_11 = 16'h3131;
   localparam logic [15:0] TAG_NATIVE_50 = 16'h3530;
   localparam logic [15:0] TAG_EMU_52 = 16'h3532;
   // byte positions within a telegram
   localparam logic [3:0] IDX_LEN_HI = 4'h0;
   localparam logic [3:0] IDX_LEN_LO = 4'h1;
   localparam logic [3:0] IDX_CODE = 4'h2;
   localparam logic [3:0] IDX_CTL = 4'h3;
   localparam logic [3:0] IDX_STAT = 4'h4;
   localparam logic [3:0] IDX_ADDR = 4'h5;
   localparam logic [3:0] IDX_CFG_LAST = 4'h9;
   localparam logic [3:0] IDX_FIX_LAST = 4'ha;
   localparam logic [2:0] RSP_BYTES_TCP = 3'h6;
   localparam logic [2:0] RSP_BYTES_BARE = 3'h4;
   // host register map
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_ADDR = 8'h04;
   localparam logic [7:0] REG_DLO = 8'h08;
   localparam logic [7:0] REG_DHI = 8'h0c;
   localparam logic [7:0] REG_RESP = 8'h10;
   localparam logic [7:0] REG_IRQ_ST = 8'h14;
   localparam logic [7:0] REG_IRQ_CLR = 8'h18;
   localparam logic [7:0] REG_IRQ_EN = 8'h1c;
   localparam int CTRL_GO = 0;
   localparam int CTRL_TCP = 1;
   localparam int CTRL_PWD = 2;
   localparam int CTRL_OP = 3;
   localparam int CTRL_CHAN = 5;
   localparam logic [1:0] OP_CFG = 2'h0;
   localparam logic [1:0] OP_FIX = 2'h1;
   localparam logic [1:0] OP_FIX_ENH = 2'h2;
   localparam int IRQ_RESP = 0;
   localparam int IRQ_REFUSED = 1;
   localparam int IRQ_MISMATCH = 2;

   typedef enum logic [1:0] {
      TGT_NONE = 2'b00, TGT_FAMILY1 = 2'b01, TGT_FAMILY2 = 2'b10
   } cfwt_target_t;
   typedef enum logic [1:0] {
      RD_NONE = 2'b00, RD_EMULATED = 2'b01, RD_NATIVE4 = 2'b10
   } cfwt_rdsrc_t;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000, ST_ISSUE = 3'b001, ST_WAIT_DONE = 3'b010,
      ST_REPLY = 3'b011, ST_WAIT_NEW = 3'b100, ST_WAIT_CARRIER = 3'b101
   } cfwt_dev_state_t;

   // index of the first byte on the link; length bytes only on tcp
   function automatic logic [3:0] first_idx(input logic tcp);
      first_idx = tcp ? IDX_LEN_HI : IDX_CODE;
   endfunction
endpackage

// ==== shared/cfwt_link_if.sv ====
`timescale 1ns/100ps
interface cfwt_link_if;
   logic tcp_mode;
   logic cmd_valid;
   logic cmd_ready;
   logic [7:0] cmd_data;
   logic cmd_last;
   logic rsp_valid;
   logic rsp_ready;
   logic [7:0] rsp_data;
   logic rsp_last;
   modport host_end (
      output tcp_mode, cmd_valid, cmd_data, cmd_last, rsp_ready,
      input cmd_ready, rsp_valid, rsp_data, rsp_last
   );
   modport device_end (
      input tcp_mode, cmd_valid, cmd_data, cmd_last, rsp_ready,
      output cmd_ready, rsp_valid, rsp_data, rsp_last
   );
endinterface

// ==== verilog/cfwt_rsp_ser.sv ====
`timescale 1ns/100ps
module cfwt_rsp_ser (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // response load
   input wire logic start,
   input wire logic tcp,
   input wire logic [7:0] code,
   input wire logic [7:0] ctl,
   input wire logic [7:0] status,
   input wire logic [7:0] count,
   // byte stream
   output logic valid,
   output logic [7:0] data,
   output logic last,
   input wire logic ready
);
   import cfwt_pkg::*;

   typedef struct packed {
      logic [2:0] left;
      logic [5:0][7:0] sh;
   } cfwt_ser_regs_t;

   cfwt_ser_regs_t s;
   cfwt_ser_regs_t next_s;

   always_comb begin
      next_s = s;
      if (start) begin
         if (tcp) begin
            next_s.sh = {count, status, ctl, code, LEN_RSP, LEN_HI};
            next_s.left = RSP_BYTES_TCP;
         end else begin
            next_s.sh = {16'h0000, count, status, ctl, code};
            next_s.left = RSP_BYTES_BARE;
         end
      end else if (s.left != 3'h0 && ready) begin
         next_s.sh = {8'h00, s.sh[5:1]};
         next_s.left = s.left - 3'h1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
      end else if (ce) begin
         s <= next_s;
      end
   end

   assign valid = s.left != 3'h0;
   assign data = s.sh[0];
   assign last = s.left == 3'h1;
endmodule

// ==== verilog/cfwt_device_end.sv ====
// Summary of operation
// - length bytes present only on tcp transport
// - host builds config write 66h header
// - host places address, data msb first
// - six-byte response on tcp, four bytes bare, with status and counter
// - enhanced config write retries until success
// - after write wait new carrier, restart
// - host needs password mode for config writes
// - status 05h on carrier leave or absence
// - no 05h between back-to-back carriers
// - no read-after-write for fixcode writes
// - family one emulation on types 02/11
// - family two emulation with type 50
// - type 52 reads emulated, 50 native
// - host builds fixcode write 1Fh telegram
// - single fixcode write tries at most once
//
// Decided for this implementation: the APB slave port and the register offsets.
`timescale 1ns/100ps
module cfwt_device_end (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // telegram link
   cfwt_link_if.device_end link,
   // carrier sensing and configuration
   input wire logic carrier_present,
   input wire logic carrier_new,
   input wire logic [15:0] tag_type,
   input wire logic verify_mode,
   // head write port
   output logic head_wr_req,
   output logic head_wr_fixcode,
   output logic [7:0] head_wr_addr,
   output logic [39:0] head_wr_data,
   output logic [15:0] head_fix_type,
   output logic [3:0] head_fix_len,
   output logic head_verify_en,
   output cfwt_pkg::cfwt_target_t head_target,
   input wire logic head_wr_done,
   input wire logic head_wr_ok,
   // fixcode read source for the selected tag type
   output cfwt_pkg::cfwt_rdsrc_t fix_read_src
);
   import cfwt_pkg::*;

   typedef struct packed {
      cfwt_dev_state_t state;
      cfwt_dev_state_t after;
      logic [3:0] rx_n;
      logic [10:0][7:0] rx_buf;
      logic [10:0][7:0] op;
      logic enhanced;
      logic fixcode;
      logic [7:0] status;
      logic [7:0] reply_cnt;
      logic carrier_prev;
      logic head_req;
      logic ser_start;
      logic [39:0] hd_data;
      cfwt_target_t target;
      logic verify_en;
      cfwt_rdsrc_t rd_src;
   } cfwt_dev_regs_t;

   cfwt_dev_regs_t s;
   cfwt_dev_regs_t next_s;
   logic cmd_ready;

   // queue a response and name the state that follows it
   function automatic cfwt_dev_regs_t start_reply(input cfwt_dev_regs_t r,
         input logic [7:0] st, input cfwt_dev_state_t nxt);
      cfwt_dev_regs_t q;
      q = r;
      q.status = st;
      q.after = nxt;
      q.state = ST_REPLY;
      q.ser_start = 1'b1;
      q.reply_cnt = r.reply_cnt + 8'h01;
      return q;
   endfunction

   // commands are only taken while no head write or reply is under way
   assign cmd_ready = s.state == ST_IDLE || s.state == ST_WAIT_NEW
      || s.state == ST_WAIT_CARRIER;
   assign link.cmd_ready = cmd_ready;

   always_comb begin
      logic [3:0] rx_idx;
      logic [7:0] code;
      logic ok_cfg;
      logic ok_fix;
      logic leave;
      rx_idx = s.rx_n + first_idx(link.tcp_mode);
      code = 8'h00;
      ok_cfg = 1'b0;
      ok_fix = 1'b0;
      // a leave that coincides with the next entry is no gap
      leave = s.carrier_prev && !carrier_present && !carrier_new;
      next_s = s;
      next_s.head_req = 1'b0;
      next_s.ser_start = 1'b0;
      next_s.carrier_prev = carrier_present;
      unique case (tag_type)
         TAG_EMU_02, TAG_EMU_11, TAG_EMU_52: next_s.rd_src = RD_EMULATED;
         TAG_NATIVE_50: next_s.rd_src = RD_NATIVE4;
         default: next_s.rd_src = RD_NONE;
      endcase

      unique case (s.state)
         ST_IDLE: begin
         end
         ST_ISSUE: begin
            next_s.head_req = 1'b1;
            next_s.state = ST_WAIT_DONE;
         end
         ST_WAIT_DONE: begin
            if (head_wr_done) begin
               if (head_wr_ok) begin
                  next_s = start_reply(next_s, STAT_OK,
                     s.enhanced ? ST_WAIT_NEW : ST_IDLE);
               end else if (!s.enhanced) begin
                  next_s = start_reply(next_s, STAT_WR_FAIL, ST_IDLE);
               end else if (carrier_present) begin
                  next_s.state = ST_ISSUE;
               end else begin
                  next_s = start_reply(next_s, STAT_NO_CARRIER, ST_WAIT_CARRIER);
               end
            end
         end
         ST_REPLY: begin
            if (link.rsp_valid && link.rsp_ready && link.rsp_last) begin
               next_s.state = s.after;
            end
         end
         ST_WAIT_NEW: begin
            if (carrier_new) begin
               next_s.state = ST_ISSUE;
            end else if (leave) begin
               next_s = start_reply(next_s, STAT_NO_CARRIER, ST_WAIT_CARRIER);
            end
         end
         ST_WAIT_CARRIER: begin
            if (carrier_present) begin
               next_s.state = ST_ISSUE;
            end
         end
         default: next_s.state = ST_IDLE;
      endcase

      // telegram reception; a complete command overrides any waiting loop
      if (link.cmd_valid && cmd_ready) begin
         if (rx_idx <= IDX_FIX_LAST) begin
            next_s.rx_buf[rx_idx] = link.cmd_data;
         end
         if (s.rx_n != 4'hf) begin
            next_s.rx_n = s.rx_n + 4'h1;
         end
         if (link.cmd_last) begin
            next_s.rx_n = 4'h0;
            code = next_s.rx_buf[IDX_CODE];
            ok_cfg = code == CMD_CFG_WR && rx_idx == IDX_CFG_LAST;
            ok_fix = (code == CMD_FIX_WR || code == CMD_FIX_WR_ENH)
               && rx_idx == IDX_FIX_LAST;
         end
      end

      if (ok_cfg || ok_fix) begin
         next_s.op = next_s.rx_buf;
         next_s.fixcode = ok_fix;
         next_s.enhanced = code != CMD_FIX_WR;
         if (ok_fix) begin
            next_s.hd_data = {next_s.rx_buf[6], next_s.rx_buf[7], next_s.rx_buf[8],
               next_s.rx_buf[9], next_s.rx_buf[10]};
            unique case (tag_type)
               TAG_EMU_02, TAG_EMU_11: next_s.target = TGT_FAMILY1;
               TAG_NATIVE_50: next_s.target = TGT_FAMILY2;
               default: next_s.target = TGT_NONE;
            endcase
         end else begin
            next_s.hd_data = {8'h00, next_s.rx_buf[6], next_s.rx_buf[7],
               next_s.rx_buf[8], next_s.rx_buf[9]};
            next_s.target = TGT_NONE;
         end
         next_s.verify_en = verify_mode && !ok_fix;
         if (carrier_present) begin
            next_s.state = ST_ISSUE;
         end else begin
            next_s = start_reply(next_s, STAT_NO_CARRIER,
               code == CMD_FIX_WR ? ST_IDLE : ST_WAIT_CARRIER);
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
      end else if (ce) begin
         s <= next_s;
      end
   end

   cfwt_rsp_ser u_ser (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .start(s.ser_start),
      .tcp(link.tcp_mode),
      .code(s.op[IDX_CODE]),
      .ctl({s.fixcode ? s.op[IDX_CTL][7:4] : 4'h0, s.op[IDX_CTL][3:0]}),
      .status(s.status),
      .count(s.reply_cnt),
      .valid(link.rsp_valid),
      .data(link.rsp_data),
      .last(link.rsp_last),
      .ready(link.rsp_ready)
   );

   assign head_wr_req = s.head_req;
   assign head_wr_fixcode = s.fixcode;
   assign head_wr_addr = s.op[IDX_ADDR];
   assign head_wr_data = s.hd_data;
   assign head_fix_type = {s.op[IDX_STAT], s.op[IDX_ADDR]};
   assign head_fix_len = s.op[IDX_CTL][7:4];
   assign head_verify_en = s.verify_en;
   assign head_target = s.target;
   assign fix_read_src = s.rd_src;
endmodule

// ==== verilog/cfwt_host_end.sv ====
`timescale 1ns/100ps
module cfwt_host_end (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // apb slave
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   // telegram link
   cfwt_link_if.host_end link
);
   import cfwt_pkg::*;

   typedef struct packed {
      logic tcp;
      logic pwd;
      logic [1:0] op;
      logic [2:0] chan;
      logic tog;
      logic [7:0] addr;
      logic [15:0] ftype;
      logic [3:0] flen;
      logic [31:0] dlo;
      logic [7:0] dhi;
      logic tx_on;
      logic [3:0] tx_idx;
      logic [3:0] tx_end;
      logic [7:0] tx_data;
      logic [3:0] rx_n;
      logic [7:0] rx_code;
      logic [7:0] rx_ctl;
      logic [7:0] rx_status;
      logic [7:0] r_code;
      logic [7:0] r_ctl;
      logic [7:0] r_status;
      logic [7:0] r_cnt;
      logic [2:0] irq_st;
      logic [2:0] irq_en;
      logic [31:0] rdata;
   } cfwt_host_regs_t;

   cfwt_host_regs_t s;
   cfwt_host_regs_t next_s;

   // command byte at a telegram position
   function automatic logic [7:0] tx_byte(input cfwt_host_regs_t r, input logic [3:0] i);
      logic fix;
      fix = r.op != OP_CFG;
      unique case (i)
         IDX_LEN_HI: tx_byte = LEN_HI;
         IDX_LEN_LO: tx_byte = fix ? LEN_FIX : LEN_CFG;
         IDX_CODE: tx_byte = r.op == OP_CFG ? CMD_CFG_WR
            : (r.op == OP_FIX ? CMD_FIX_WR : CMD_FIX_WR_ENH);
         IDX_CTL: tx_byte = {fix ? r.flen : 4'h0, r.chan, r.tog};
         4'h4: tx_byte = fix ? r.ftype[15:8] : 8'h00;
         4'h5: tx_byte = fix ? r.ftype[7:0] : r.addr;
         4'h6: tx_byte = r.dlo[31:24];
         4'h7: tx_byte = r.dlo[23:16];
         4'h8: tx_byte = r.dlo[15:8];
         4'h9: tx_byte = r.dlo[7:0];
         default: tx_byte = r.dhi;
      endcase
   endfunction

   always_comb begin
      logic acc;
      logic [2:0] set;
      logic [2:0] clr;
      logic [3:0] rx_idx;
      acc = psel && penable;
      set = 3'h0;
      clr = 3'h0;
      rx_idx = s.rx_n + first_idx(s.tcp);
      next_s = s;

      // command stream
      if (s.tx_on && link.cmd_ready) begin
         if (s.tx_idx == s.tx_end) begin
            next_s.tx_on = 1'b0;
         end else begin
            next_s.tx_idx = s.tx_idx + 4'h1;
            next_s.tx_data = tx_byte(s, s.tx_idx + 4'h1);
         end
      end

      // register writes
      if (acc && pwrite) begin
         unique case (paddr)
            REG_CTRL: begin
               next_s.tcp = pwdata[CTRL_TCP];
               next_s.pwd = pwdata[CTRL_PWD];
               next_s.op = pwdata[CTRL_OP +: 2];
               next_s.chan = pwdata[CTRL_CHAN +: 3];
               if (pwdata[CTRL_GO] && !s.tx_on) begin
                  if (next_s.op == OP_CFG && !next_s.pwd) begin
                     set[IRQ_REFUSED] = 1'b1;
                  end else begin
                     next_s.tog = ~s.tog;
                     next_s.tx_on = 1'b1;
                     next_s.tx_idx = first_idx(next_s.tcp);
                     next_s.tx_end = next_s.op == OP_CFG ? IDX_CFG_LAST : IDX_FIX_LAST;
                     next_s.tx_data = tx_byte(next_s, first_idx(next_s.tcp));
                  end
               end
            end
            REG_ADDR: begin
               next_s.addr = pwdata[7:0];
               next_s.ftype = pwdata[23:8];
               next_s.flen = pwdata[27:24];
            end
            REG_DLO: next_s.dlo = pwdata;
            REG_DHI: next_s.dhi = pwdata[7:0];
            REG_IRQ_CLR: clr = pwdata[2:0];
            REG_IRQ_EN: next_s.irq_en = pwdata[2:0];
            default: begin
            end
         endcase
      end

      // response stream
      if (link.rsp_valid) begin
         unique case (rx_idx)
            IDX_CODE: next_s.rx_code = link.rsp_data;
            IDX_CTL: next_s.rx_ctl = link.rsp_data;
            IDX_STAT: next_s.rx_status = link.rsp_data;
            default: begin
            end
         endcase
         if (s.rx_n != 4'hf) begin
            next_s.rx_n = s.rx_n + 4'h1;
         end
         if (link.rsp_last) begin
            next_s.rx_n = 4'h0;
            next_s.r_code = s.rx_code;
            next_s.r_ctl = s.rx_ctl;
            next_s.r_status = s.rx_status;
            next_s.r_cnt = link.rsp_data;
            set[IRQ_RESP] = 1'b1;
            if (s.rx_ctl[3:0] != {s.chan, s.tog}) begin
               set[IRQ_MISMATCH] = 1'b1;
            end
         end
      end
      next_s.irq_st = (s.irq_st & ~clr) | set;

      // read data captured in the setup phase
      if (psel && !penable) begin
         unique case (paddr)
            REG_CTRL: next_s.rdata = {24'h0, s.chan, s.op, s.pwd, s.tcp, 1'b0};
            REG_ADDR: next_s.rdata = {4'h0, s.flen, s.ftype, s.addr};
            REG_DLO: next_s.rdata = s.dlo;
            REG_DHI: next_s.rdata = {24'h0, s.dhi};
            REG_RESP: next_s.rdata = {3'h0, s.tx_on, s.r_ctl[3:0], s.r_code,
               s.r_cnt, s.r_status};
            REG_IRQ_ST: next_s.rdata = {29'h0, s.irq_st};
            REG_IRQ_EN: next_s.rdata = {29'h0, s.irq_en};
            default: next_s.rdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
      end else if (ce) begin
         s <= next_s;
      end
   end

   assign prdata = s.rdata;
   assign pready = 1'b1;
   assign pslverr = psel && penable && paddr != REG_CTRL && paddr != REG_ADDR
      && paddr != REG_DLO && paddr != REG_DHI && paddr != REG_RESP
      && paddr != REG_IRQ_ST && paddr != REG_IRQ_CLR && paddr != REG_IRQ_EN;
   assign irq = |(s.irq_st & s.irq_en);
   assign link.tcp_mode = s.tcp;
   assign link.cmd_valid = s.tx_on;
   assign link.cmd_data = s.tx_data;
   assign link.cmd_last = s.tx_on && s.tx_idx == s.tx_end;
   assign link.rsp_ready = 1'b1;
endmodule

// ==== tb/cfwt_link_monitor.sv ====
`timescale 1ns/100ps
module cfwt_link_monitor (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // link signals
   input wire logic tcp_mode,
   input wire logic cmd_valid,
   input wire logic cmd_ready,
   input wire logic [7:0] cmd_data,
   input wire logic cmd_last,
   input wire logic rsp_valid,
   input wire logic rsp_ready,
   input wire logic [7:0] rsp_data,
   input wire logic rsp_last
);
   import cfwt_pkg::*;
   default clocking dc @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // byte counts of the telegrams in flight, mapped to telegram byte numbers
   logic [3:0] ci, ri, cx, rx;
   logic [7:0] cc, ct, cl;
   assign cx = ci + (tcp_mode ? 4'h0 : 4'h2);
   assign rx = ri + (tcp_mode ? 4'h0 : 4'h2);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ci <= 4'h0;
         ri <= 4'h0;
         cc <= 8'h00;
         ct <= 8'h00;
         cl <= 8'h00;
      end else begin
         if (cmd_valid && cmd_ready) begin
            ci <= cmd_last ? 4'h0 : ci + 4'h1;
            if (cx == IDX_LEN_LO) cl <= cmd_data;
            if (cx == IDX_CODE) cc <= cmd_data;
            if (cx == IDX_CTL) ct <= cmd_data;
         end
         if (rsp_valid && rsp_ready) ri <= rsp_last ? 4'h0 : ri + 4'h1;
      end
   end
   cmd_len_hi_a: assert property (
      cmd_valid && tcp_mode && ci == 4'h0 |-> cmd_data == LEN_HI)
      else $error("command length high byte wrong");
   cmd_len_lo_a: assert property (
      cmd_valid && cmd_last && tcp_mode |-> cl == (cc == CMD_CFG_WR ? LEN_CFG : LEN_FIX))
      else $error("command length low byte wrong");
   cmd_end_a: assert property (
      cmd_valid && cmd_last |-> cx == (cc == CMD_CFG_WR ? IDX_CFG_LAST : IDX_FIX_LAST))
      else $error("command ends at wrong byte");
   cfg_ctl_a: assert property (
      cmd_valid && cx == IDX_CTL && cc == CMD_CFG_WR |-> cmd_data[7:4] == 4'h0)
      else $error("config command control nibble not zero");
   cfg_rsvd_a: assert property (
      cmd_valid && cx == IDX_STAT && cc == CMD_CFG_WR |-> cmd_data == 8'h00)
      else $error("config command reserved byte not zero");
   rsp_len_a: assert property (
      rsp_valid && rx < IDX_CODE |-> rsp_data == (rx == IDX_LEN_HI ? LEN_HI : LEN_RSP))
      else $error("response length byte wrong");
   rsp_code_a: assert property (
      rsp_valid && rx == IDX_CODE |-> rsp_data == cc)
      else $error("response code differs from command");
   rsp_echo_a: assert property (
      rsp_valid && rx == IDX_CTL |-> rsp_data == (cc == CMD_CFG_WR ? {4'h0, ct[3:0]} : ct))
      else $error("response channel or toggle not echoed");
   rsp_end_a: assert property (
      rsp_valid |-> rsp_last == (rx == IDX_ADDR))
      else $error("response length wrong");
   rsp_run_a: assert property (
      rsp_valid && !rsp_last |=> rsp_valid)
      else $error("response bytes not contiguous");
endmodule

// ==== tb/config_and_fixcode_write_telegrams_tb.sv ====
`timescale 1ns/100ps
module config_and_fixcode_write_telegrams_tb;
   import cfwt_pkg::*;
   typedef struct packed {
      logic [1:0] op;
      logic tcp;
      logic [2:0] ch;
      logic [15:0] tag;
      logic car;
      logic [1:0] nf;
      logic [7:0] st;
      cfwt_target_t tgt;
   } cfwt_row_t;
   // op, transport, channel, tag type, carrier, failed writes, status, target
   cfwt_row_t rows [5] = '{
      '{OP_FIX, 1'b1, 3'h3, TAG_EMU_02, 1'b1, 2'h0, STAT_OK, TGT_FAMILY1},
      '{OP_FIX, 1'b0, 3'h5, TAG_NATIVE_50, 1'b1, 2'h1, STAT_WR_FAIL, TGT_FAMILY2},
      '{OP_FIX, 1'b1, 3'h0, TAG_EMU_11, 1'b0, 2'h0, STAT_NO_CARRIER, TGT_NONE},
      '{OP_CFG, 1'b1, 3'h2, TAG_EMU_02, 1'b1, 2'h2, STAT_OK, TGT_NONE},
      '{OP_FIX_ENH, 1'b0, 3'h7, TAG_EMU_11, 1'b1, 2'h0, STAT_OK, TGT_FAMILY1}};
   logic [15:0] rd_tag [5] = '{TAG_EMU_02, TAG_EMU_11, TAG_EMU_52, TAG_NATIVE_50, 16'h3030};
   cfwt_rdsrc_t rd_src [5] = '{RD_EMULATED, RD_EMULATED, RD_EMULATED, RD_NATIVE4, RD_NONE};
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic carrier_present, carrier_new, verify_mode, head_wr_req, head_verify_en;
   logic head_wr_done, head_wr_ok, serr, tog, s_ven;
   logic [15:0] tag_type;
   logic [39:0] head_wr_data, s_data;
   logic head_wr_fixcode;
   logic [3:0] head_fix_len;
   logic [15:0] head_fix_type;
   logic [7:0] head_wr_addr;
   logic [28:0] s_fix;
   logic [7:0] rc;
   cfwt_target_t head_target, s_tgt;
   cfwt_rdsrc_t fix_read_src;
   int mismatches = 0, comparisons = 0, cycles = 0;
   int writes = 0, base = 0, nfail = 0, dly = 0;
   cfwt_link_if link();
   cfwt_host_end i_cfwt_host_end (.pclk, .presetn, .ce(1'b1), .paddr, .psel, .penable,
      .pwrite, .pwdata, .prdata, .pready, .pslverr, .irq, .link);
   cfwt_device_end i_cfwt_device_end (.pclk, .presetn, .ce(1'b1), .link, .carrier_present,
      .carrier_new, .tag_type, .verify_mode, .head_wr_req, .head_wr_fixcode,
      .head_wr_addr, .head_wr_data, .head_fix_type, .head_fix_len, .head_verify_en,
      .head_target, .head_wr_done, .head_wr_ok, .fix_read_src);
   cfwt_link_monitor i_mon (.pclk, .presetn, .tcp_mode(link.tcp_mode),
      .cmd_valid(link.cmd_valid), .cmd_ready(link.cmd_ready), .cmd_data(link.cmd_data),
      .cmd_last(link.cmd_last), .rsp_valid(link.rsp_valid), .rsp_ready(link.rsp_ready),
      .rsp_data(link.rsp_data), .rsp_last(link.rsp_last));
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   // head model: answers each write three cycles later, failing the first nfail
   always @(posedge pclk) begin
      head_wr_done <= 1'b0;
      cycles <= cycles + 1;
      if (head_wr_req === 1'b1) begin
         writes <= writes + 1;
         dly <= 3;
         s_tgt <= head_target;
         s_ven <= head_verify_en;
         s_data <= head_wr_data;
         s_fix <= {head_wr_fixcode, head_fix_len, head_fix_type, head_wr_addr};
      end else if (dly == 1) begin
         head_wr_done <= 1'b1;
         head_wr_ok <= (writes - base) > nfail;
         dly <= 0;
      end else if (dly > 1) begin
         dly <= dly - 1;
      end
      if (cycles == 20000) begin
         mismatches++;
         close_out();
      end
   end
   task automatic close_out();
      if (mismatches == 0 && comparisons > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input logic [39:0] s, input logic [39:0] e);
      comparisons++;
      if (s !== e) begin
         mismatches++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      serr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   function automatic logic [7:0] code_of(input logic [1:0] op);
      code_of = op == OP_CFG ? CMD_CFG_WR : op == OP_FIX ? CMD_FIX_WR : CMD_FIX_WR_ENH;
   endfunction
   task automatic resp(input logic [7:0] st, input logic [1:0] op, input logic [2:0] ch);
      @(posedge pclk iff irq === 1'b1);
      rc = rc + 8'h01;
      apb(1'b0, REG_RESP, 32'h0);
      chk(rd, {4'h0, ch, tog, code_of(op), rc, st});
      apb(1'b0, REG_IRQ_ST, 32'h0);
      chk(rd, 32'h1);
      apb(1'b1, REG_IRQ_CLR, 32'h7);
      chk(irq, 1'b0);
   endtask
   initial begin
      presetn = 1'b0;
      {paddr, psel, penable, pwrite, pwdata} = '0;
      {carrier_present, carrier_new, verify_mode} = '0;
      tag_type = 16'h0;
      tog = 1'b0;
      rc = 8'h00;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, REG_RESP, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, REG_IRQ_EN, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 8'h40, 32'h0);
      chk({rd, serr}, 33'h1);
      apb(1'b1, REG_ADDR, 32'h05313121);
      apb(1'b1, REG_DLO, 32'h41424344);
      apb(1'b1, REG_DHI, 32'h45);
      apb(1'b1, REG_IRQ_EN, 32'h7);
      verify_mode <= 1'b1;
      carrier_present <= 1'b1;
      foreach (rd_tag[i]) begin
         tag_type <= rd_tag[i];
         repeat (2) @(posedge pclk);
         chk(fix_read_src, rd_src[i]);
      end
      base = writes;
      apb(1'b1, REG_CTRL, {24'h0, 3'h1, OP_CFG, 1'b0, 1'b1, 1'b1});
      apb(1'b0, REG_IRQ_ST, 32'h0);
      chk({rd, irq}, 33'h5);
      apb(1'b1, REG_IRQ_CLR, 32'h7);
      chk(writes - base, 0);
      foreach (rows[i]) begin
         tag_type <= rows[i].tag;
         carrier_present <= rows[i].car;
         nfail = rows[i].nf;
         base = writes;
         apb(1'b1, REG_CTRL, {24'h0, rows[i].ch, rows[i].op, 1'b1, rows[i].tcp, 1'b1});
         tog = ~tog;
         resp(rows[i].st, rows[i].op, rows[i].ch);
         chk(writes - base, !rows[i].car ? 0 : rows[i].op == OP_FIX ? 1 : rows[i].nf + 1);
         if (rows[i].car) begin
            chk(s_tgt, rows[i].tgt);
            chk(s_ven, rows[i].op == OP_CFG);
            chk(s_data, rows[i].op == OP_CFG ? 40'h0041424344 : 40'h4142434445);
            chk(s_fix, rows[i].op == OP_CFG ? 29'h2121 : 29'h15313131);
         end
      end
      // enhanced loop: a carrier swap restarts, leaving reports absence
      base = writes;
      carrier_present <= 1'b0;
      carrier_new <= 1'b1;
      @(posedge pclk);
      carrier_present <= 1'b1;
      carrier_new <= 1'b0;
      resp(STAT_OK, OP_FIX_ENH, 3'h7);
      chk(writes - base, 1);
      carrier_present <= 1'b0;
      resp(STAT_NO_CARRIER, OP_FIX_ENH, 3'h7);
      carrier_present <= 1'b1;
      carrier_new <= 1'b1;
      @(posedge pclk);
      carrier_new <= 1'b0;
      resp(STAT_OK, OP_FIX_ENH, 3'h7);
      chk(writes - base, 2);
      close_out();
   end
endmodule
